// ===== user_scan_macro_top.v
// Boundary-scan test logic: test access port controller, instruction
// register, boundary chain, bypass and user/configuration register hooks.
// Assumes the test pins arrive asynchronously and clk runs well above TCK.
`timescale 1ns/1ps
`default_nettype none
`include "user_scan_macro_consts.vh"

// Notes on behaviour
// RULE1 - Bypass, sample/preload and external-test instructions are supported.
// RULE2 - With scan enabled, three user pins are test inputs, one is output.
// RULE3 - No test reset pin; only mode-select sequences reset the controller. Here rst_n low or scanEnable low also resets it.
// RULE4 - Sixteen-state controller, decoded instruction register, selectable data registers.
// RULE5 - Every pad block has input, output and tristate cells.
// RULE6 - Non-pad-block pins contribute only the cell matching their direction.
// RULE7 - Program, configuration clock and done pins are not in the chain.
// RULE8 - Capture under external test loads every boundary cell at once.
// RULE9 - Bit 0 observes enable, bit 1 observes value, last bit updates internally.
// RULE10 - Leading cells capture internal signals; final cell drives an internal net.
// RULE11 - Bypass is one flip-flop between serial input and output.
// RULE12 - Two select outputs follow the two decoded user instructions.
// RULE13 - Each user instruction routes its user serial input to the output.
// RULE14 - Data-register clock is exported to user logic.
// RULE15 - Exported gate equals inverted AND of test clock and run-test/idle.
// RULE16 - Pad block cell order is input, output, tristate.
// RULE17 - Mode pins zero and two add input cells; mode pin one adds three.
// RULE18 - Configuration load and readback instructions exist.
// RULE19 - Outside party holds mode-select high to keep the controller in reset.
// RULE20 - Standard transitions, sample on rising edge, output on falling, drive only shifting.
// RULE21 - Undefined instruction codes act as bypass.
module user_scan_macro_top
(
  input  wire                  clk,
  input  wire                  rst_n,
  input  wire                  scanEnable,
  input  wire                  tck,
  input  wire                  tms,
  input  wire                  tdi,
  output reg                   tdo,
  output reg                   tdoOe_n,
  input  wire [`PAD_COUNT-1:0] padIn,
  output reg  [`PAD_COUNT-1:0] padOut,
  output reg  [`PAD_COUNT-1:0] padOe_n,
  input  wire [`PAD_COUNT-1:0] coreOut,
  input  wire [`PAD_COUNT-1:0] coreOe_n,
  input  wire                  modeSelectBitZero,
  input  wire                  modeSelectBitTwo,
  output reg                   modeSelectBitOne,
  output reg                   modeSelectBitOneOe_n,
  input  wire                  modeOneCoreOut,
  input  wire                  modeOneCoreOe_n,
  input  wire                  obsEnableProbe,
  input  wire                  obsValueProbe,
  output wire                  scanInternalUpdateCell,
  output reg                   userInstrOneSelect,
  output reg                   userInstrTwoSelect,
  input  wire                  userChainOneSerialIn,
  input  wire                  userChainTwoSerialIn,
  output reg                   userDataRegClock,
  output reg                   userTckRuntestGate,
  output reg                   scanDataIn,
  output reg                   configLoadSelect,
  output reg                   configShiftStrobe,
  input  wire                  configSerialOut,
  output reg                   readbackSelect,
  output reg                   readbackShiftStrobe,
  input  wire                  readbackSerialIn
);

  localparam RESET_ST   = 4'h0;
  localparam IDLE_ST    = 4'h1;
  localparam SEL_DR_ST  = 4'h2;
  localparam CAP_DR_ST  = 4'h3;
  localparam SH_DR_ST   = 4'h4;
  localparam EX1_DR_ST  = 4'h5;
  localparam PA_DR_ST   = 4'h6;
  localparam EX2_DR_ST  = 4'h7;
  localparam UPD_DR_ST  = 4'h8;
  localparam SEL_IR_ST  = 4'h9;
  localparam CAP_IR_ST  = 4'ha;
  localparam SH_IR_ST   = 4'hb;
  localparam EX1_IR_ST  = 4'hc;
  localparam PA_IR_ST   = 4'hd;
  localparam EX2_IR_ST  = 4'he;
  localparam UPD_IR_ST  = 4'hf;

  // Two-stage synchronisers for the test pins and the mode/pad inputs
  reg [2:0]            tapS1_q;
  reg [2:0]            tapS2_q;
  reg [`PAD_COUNT+1:0] pinS1_q;
  reg [`PAD_COUNT+1:0] pinS2_q;
  reg                  tckPrev_q;
  wire                 tckS   = tapS2_q[2];
  wire                 tmsS   = tapS2_q[1];
  wire                 tdiS   = tapS2_q[0];
  wire                 tckRise = tckS & ~tckPrev_q;
  wire                 tckFall = ~tckS & tckPrev_q;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      tapS1_q   <= 3'h0;
      tapS2_q   <= 3'h0;
      pinS1_q   <= {(`PAD_COUNT+2){1'b0}};
      pinS2_q   <= {(`PAD_COUNT+2){1'b0}};
      tckPrev_q <= 1'b0;
    end
    else
    begin
      tapS1_q   <= {tck, tms, tdi}; // RULE2
      tapS2_q   <= tapS1_q;
      pinS1_q   <= {modeSelectBitTwo, modeSelectBitZero, padIn};
      pinS2_q   <= pinS1_q;
      tckPrev_q <= tckS;
    end
  end

  // TAP controller
  reg [3:0] state_q;
  reg [3:0] state_d;

  always @*
  begin
    state_d = state_q;
    case (state_q) // RULE20
      RESET_ST:  state_d = tmsS ? RESET_ST  : IDLE_ST;
      IDLE_ST:   state_d = tmsS ? SEL_DR_ST : IDLE_ST;
      SEL_DR_ST: state_d = tmsS ? SEL_IR_ST : CAP_DR_ST;
      CAP_DR_ST: state_d = tmsS ? EX1_DR_ST : SH_DR_ST;
      SH_DR_ST:  state_d = tmsS ? EX1_DR_ST : SH_DR_ST;
      EX1_DR_ST: state_d = tmsS ? UPD_DR_ST : PA_DR_ST;
      PA_DR_ST:  state_d = tmsS ? EX2_DR_ST : PA_DR_ST;
      EX2_DR_ST: state_d = tmsS ? UPD_DR_ST : SH_DR_ST;
      UPD_DR_ST: state_d = tmsS ? SEL_DR_ST : IDLE_ST;
      SEL_IR_ST: state_d = tmsS ? RESET_ST  : CAP_IR_ST;
      CAP_IR_ST: state_d = tmsS ? EX1_IR_ST : SH_IR_ST;
      SH_IR_ST:  state_d = tmsS ? EX1_IR_ST : SH_IR_ST;
      EX1_IR_ST: state_d = tmsS ? UPD_IR_ST : PA_IR_ST;
      PA_IR_ST:  state_d = tmsS ? EX2_IR_ST : PA_IR_ST;
      EX2_IR_ST: state_d = tmsS ? UPD_IR_ST : SH_IR_ST;
      UPD_IR_ST: state_d = tmsS ? SEL_DR_ST : IDLE_ST;
      default:   state_d = RESET_ST;
    endcase
  end

  // No test reset pin: only TMS held high (or the scan option off, or rst_n low) resets
  always @(posedge clk)
  begin
    if (!rst_n || !scanEnable)
      state_q <= RESET_ST; // RULE3 RULE19
    else if (tckRise)
      state_q <= state_d; // RULE4
  end

  // Instruction register
  reg [`IR_WIDTH-1:0] irShift_q;
  reg [`IR_WIDTH-1:0] instr_q;

  always @(posedge clk)
  begin
    if (!rst_n || state_q == RESET_ST)
    begin
      irShift_q <= `IR_CAPTURE_VAL;
      instr_q   <= `IR_RESET_VAL;
    end
    else
    begin
      if (tckRise && state_q == CAP_IR_ST)
        irShift_q <= `IR_CAPTURE_VAL;
      else if (tckRise && state_q == SH_IR_ST)
        irShift_q <= {tdiS, irShift_q[`IR_WIDTH-1:1]};
      if (tckFall && state_q == UPD_IR_ST)
        instr_q <= irShift_q;
    end
  end

  // Instruction decode; reserved code falls through to bypass
  wire extSel  = instr_q == `IR_EXTEST; // RULE1
  wire bsSel   = extSel || instr_q == `IR_SAMPLE; // RULE1
  wire u1Sel   = instr_q == `IR_USER_ONE; // RULE12
  wire u2Sel   = instr_q == `IR_USER_TWO; // RULE12
  wire rbSel   = instr_q == `IR_READBACK; // RULE18
  wire cfgSel  = instr_q == `IR_CONFIGURE; // RULE18
  wire bypSel  = !(bsSel || u1Sel || u2Sel || rbSel || cfgSel); // RULE21

  wire capDr   = tckRise && state_q == CAP_DR_ST;
  wire shiftDr = tckRise && state_q == SH_DR_ST;
  wire updDr   = tckFall && state_q == UPD_DR_ST;

  // Boundary chain
  wire [`CHAIN_LEN-1:0] chainPar;
  wire [`CHAIN_LEN-1:0] chainCap;
  wire [`CHAIN_LEN-1:0] chainUpd;
  wire [`CHAIN_LEN-1:0] chainSer = {tdiS, chainCap[`CHAIN_LEN-1:1]};

  assign chainPar[`BIT_OBS_ENABLE] = obsEnableProbe; // RULE9 RULE10
  assign chainPar[`BIT_OBS_VALUE]  = obsValueProbe; // RULE9 RULE10
  assign chainPar[`BIT_MODE_ZERO]  = pinS2_q[`PAD_COUNT]; // RULE6 RULE17
  assign chainPar[`BIT_MODE_TWO]   = pinS2_q[`PAD_COUNT+1]; // RULE6 RULE17
  assign chainPar[`BIT_MODE_ONE+`CELL_IN]  = modeSelectBitOne; // RULE17
  assign chainPar[`BIT_MODE_ONE+`CELL_OUT] = modeOneCoreOut;
  assign chainPar[`BIT_MODE_ONE+`CELL_TRI] = modeOneCoreOe_n;
  assign chainPar[`BIT_INT_UPDATE] = `UPD_CELL_CAPTURE;
  // Program, configuration clock and done pins simply have no cells here
  assign scanInternalUpdateCell = chainUpd[`BIT_INT_UPDATE]; // RULE7 RULE10

  genvar p;
  generate
    for (p = 0; p < `PAD_COUNT; p = p + 1)
    begin : padCells
      // Input, then output, then tristate within every pad block
      assign chainPar[`BIT_PAD_BASE+p*`CELLS_PER_PAD+`CELL_IN]  = pinS2_q[p]; // RULE5 RULE16
      assign chainPar[`BIT_PAD_BASE+p*`CELLS_PER_PAD+`CELL_OUT] = coreOut[p]; // RULE5 RULE16
      assign chainPar[`BIT_PAD_BASE+p*`CELLS_PER_PAD+`CELL_TRI] = coreOe_n[p]; // RULE5 RULE16
    end
  endgenerate

  genvar c;
  generate
    for (c = 0; c < `CHAIN_LEN; c = c + 1)
    begin : cells
      scan_cell u_cell
      (
        .clk     (clk),
        .rst_n   (rst_n),
        .capEn   (capDr && bsSel), // RULE8
        .shiftEn (shiftDr && bsSel),
        .updEn   (updDr && bsSel),
        .parIn   (chainPar[c]),
        .serIn   (chainSer[c]),
        .capQ    (chainCap[c]),
        .updQ    (chainUpd[c])
      );
    end
  endgenerate

  // Pad drivers: update cells take over only under external test
  integer k;
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      padOut               <= {`PAD_COUNT{1'b0}};
      padOe_n              <= {`PAD_COUNT{1'b1}};
      modeSelectBitOne     <= 1'b0;
      modeSelectBitOneOe_n <= 1'b1;
    end
    else
    begin
      for (k = 0; k < `PAD_COUNT; k = k + 1)
      begin
        padOut[k]  <= extSel ? chainUpd[`BIT_PAD_BASE+k*`CELLS_PER_PAD+`CELL_OUT] : coreOut[k];
        padOe_n[k] <= extSel ? chainUpd[`BIT_PAD_BASE+k*`CELLS_PER_PAD+`CELL_TRI] : coreOe_n[k];
      end
      modeSelectBitOne     <= extSel ? chainUpd[`BIT_MODE_ONE+`CELL_OUT] : modeOneCoreOut;
      modeSelectBitOneOe_n <= extSel ? chainUpd[`BIT_MODE_ONE+`CELL_TRI] : modeOneCoreOe_n;
    end
  end

  // Bypass register
  reg bypass_q;
  always @(posedge clk)
  begin
    if (!rst_n)
      bypass_q <= 1'b0;
    else if (capDr && bypSel)
      bypass_q <= `BYPASS_CAPTURE;
    else if (shiftDr && bypSel)
      bypass_q <= tdiS; // RULE11
  end

  // Serial output source
  reg tdoSrc;
  always @*
  begin
    if (state_q == SH_IR_ST)
      tdoSrc = irShift_q[0];
    else if (bsSel)
      tdoSrc = chainCap[0];
    else if (u1Sel)
      tdoSrc = userChainOneSerialIn; // RULE13
    else if (u2Sel)
      tdoSrc = userChainTwoSerialIn; // RULE13
    else if (rbSel)
      tdoSrc = readbackSerialIn; // RULE18
    else if (cfgSel)
      tdoSrc = configSerialOut; // RULE18
    else
      tdoSrc = bypass_q; // RULE11 RULE21
  end

  // Output changes on the falling test clock, enabled only while shifting
  always @(posedge clk)
  begin
    if (!rst_n || !scanEnable)
    begin
      tdo     <= 1'b0;
      tdoOe_n <= 1'b1;
    end
    else if (tckFall)
    begin
      tdo     <= tdoSrc; // RULE20
      tdoOe_n <= !(state_q == SH_DR_ST || state_q == SH_IR_ST); // RULE20
    end
  end

  // User-side and configuration hooks; one cycle behind the sampled pins
  wire drClkState = state_q == CAP_DR_ST || state_q == SH_DR_ST;
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      userInstrOneSelect  <= 1'b0;
      userInstrTwoSelect  <= 1'b0;
      userDataRegClock    <= 1'b0;
      userTckRuntestGate  <= 1'b1;
      scanDataIn          <= 1'b0;
      configLoadSelect    <= 1'b0;
      configShiftStrobe   <= 1'b0;
      readbackSelect      <= 1'b0;
      readbackShiftStrobe <= 1'b0;
    end
    else
    begin
      userInstrOneSelect  <= u1Sel; // RULE12
      userInstrTwoSelect  <= u2Sel; // RULE12
      userDataRegClock    <= tckS && drClkState; // RULE14
      userTckRuntestGate  <= !(tckS && state_q == IDLE_ST); // RULE15
      scanDataIn          <= tdiS;
      configLoadSelect    <= cfgSel; // RULE18
      configShiftStrobe   <= shiftDr && cfgSel;
      readbackSelect      <= rbSel; // RULE18
      readbackShiftStrobe <= shiftDr && rbSel;
    end
  end

endmodule // user_scan_macro_top

`default_nettype wire

// ===== user_scan_macro_consts.vh
// Constants for the boundary-scan test logic: instruction codes, widths,
// chain layout and register reset values. Included by bare name.
`ifndef USER_SCAN_MACRO_CONSTS_VH
`define USER_SCAN_MACRO_CONSTS_VH

// Instruction register
`define IR_WIDTH        3
`define IR_EXTEST       3'h0
`define IR_SAMPLE       3'h1
`define IR_USER_ONE     3'h2
`define IR_USER_TWO     3'h3
`define IR_READBACK     3'h4
`define IR_CONFIGURE    3'h5
`define IR_RESERVED     3'h6
`define IR_BYPASS       3'h7
`define IR_CAPTURE_VAL  3'h1
`define IR_RESET_VAL    3'h7

// Pad blocks carried by this instance, three cells each
`define PAD_COUNT       4
`define CELLS_PER_PAD   3
`define CELL_IN         0
`define CELL_OUT        1
`define CELL_TRI        2

// Boundary chain layout, bit 0 sits next to the serial output
`define BIT_OBS_ENABLE  0
`define BIT_OBS_VALUE   1
`define BIT_PAD_BASE    2
`define BIT_MODE_ZERO   (`BIT_PAD_BASE + `PAD_COUNT * `CELLS_PER_PAD)
`define BIT_MODE_TWO    (`BIT_MODE_ZERO + 1)
`define BIT_MODE_ONE    (`BIT_MODE_ZERO + 2)
`define BIT_INT_UPDATE  (`BIT_MODE_ONE + `CELLS_PER_PAD)
`define CHAIN_LEN       (`BIT_INT_UPDATE + 1)

// Values loaded in capture states
`define BYPASS_CAPTURE  1'b0
`define UPD_CELL_CAPTURE 1'b0

`endif

// ===== scan_cell.v
// One boundary-scan cell: a capture/shift stage and an update stage.
// Assumes enables are single-cycle pulses derived from sampled test clock edges.
`timescale 1ns/1ps
`default_nettype none

module scan_cell
(
  input  wire clk,
  input  wire rst_n,
  input  wire capEn,
  input  wire shiftEn,
  input  wire updEn,
  input  wire parIn,
  input  wire serIn,
  output reg  capQ,
  output reg  updQ
);

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      capQ <= 1'b0;
      updQ <= 1'b0;
    end
    else
    begin
      if (capEn)
        capQ <= parIn;
      else if (shiftEn)
        capQ <= serIn;
      // Update stage holds steady while shifting so pads do not ripple
      if (updEn)
        updQ <= capQ;
    end
  end

endmodule // scan_cell

`default_nettype wire

// ===== test_ctl_model.sv
// Board test controller model: drives the test clock, mode select and serial data.
// Assumes clk is the bench clock; one test clock period is 8 clk (400 ns).
`timescale 1ns/1ps
`default_nettype none

module test_ctl_model
(
  input  wire logic clk,
  input  wire logic tdo,
  output logic      tck,
  output logic      tms,
  output logic      tdi
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // Test clock stands still between calls; tdo is read just before each rise
  task automatic step(input logic tmsV, input logic tdiV, output logic tdoV);
    @(negedge clk);
    tms <= tmsV;
    tdi <= tdiV;
    repeat (3) @(negedge clk);
    tdoV = tdo;
    tck <= 1'b1;
    repeat (4) @(negedge clk);
    tck <= 1'b0;
  endtask

  // Idle steps toggle tdi so a stale level can never pass for shifted data
  task automatic tapReset();
    logic d;
    repeat (5) step(1'b1, ~tdi, d);
    step(1'b0, ~tdi, d);
  endtask

  task automatic scan(input logic isIr, input int n, input logic [20:0] din,
                      output logic [20:0] dout);
    logic d;
    dout = '0;
    step(1'b1, ~tdi, d);
    if (isIr)
      step(1'b1, ~tdi, d);
    step(1'b0, ~tdi, d);
    step(1'b0, ~tdi, d);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], d);
      dout[i] = d;
    end
    step(1'b1, ~tdi, d);
    step(1'b0, ~tdi, d);
  endtask
endmodule // test_ctl_model

`default_nettype wire

// ===== user_scan_macro_props.sv
// Checker for the boundary-scan test logic, bound to its top module.
// Assumes the test pins pass a two-stage synchroniser before use.
`timescale 1ns/1ps
`default_nettype none
`include "user_scan_macro_consts.vh"

module user_scan_macro_checker
(
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  scanEnable,
  input wire logic                  tck,
  input wire logic                  tdo,
  input wire logic                  tdoOe_n,
  input wire logic [`PAD_COUNT-1:0] padOut,
  input wire logic [`PAD_COUNT-1:0] padOe_n,
  input wire logic [`PAD_COUNT-1:0] coreOut,
  input wire logic [`PAD_COUNT-1:0] coreOe_n,
  input wire logic                  modeSelectBitOne,
  input wire logic                  modeOneCoreOut,
  input wire logic                  userInstrOneSelect,
  input wire logic                  userInstrTwoSelect,
  input wire logic                  userDataRegClock,
  input wire logic                  userTckRuntestGate,
  input wire logic                  configLoadSelect,
  input wire logic                  configShiftStrobe,
  input wire logic                  readbackSelect,
  input wire logic                  readbackShiftStrobe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence sSelHeld;
    (userInstrOneSelect || userInstrTwoSelect || readbackSelect) [*3];
  endsequence
  sequence sOnePulse(s);
    s ##1 !s;
  endsequence

  AST_PAD_PASS: assert property (sSelHeld |-> padOut == $past(coreOut)
    && padOe_n == $past(coreOe_n) && modeSelectBitOne == $past(modeOneCoreOut))
    else $error("pads not following core outside external test");
  AST_OE_OFF: assert property (!scanEnable [*4] |-> tdoOe_n)
    else $error("serial output driven with scan disabled");
  AST_GATE_RST: assert property (disable iff (1'b0) !rst_n |=> userTckRuntestGate)
    else $error("idle gate low after reset");
  AST_GATE_NAND: assert property (!userTckRuntestGate |->
    $past(tck, 2) || $past(tck, 3) || $past(tck, 4))
    else $error("idle gate low without test clock high");
  AST_DRCK: assert property (userDataRegClock |->
    $past(tck, 2) || $past(tck, 3) || $past(tck, 4))
    else $error("data register clock high without test clock high");
  // Disabling the scan option clears tdo at once, whatever the test clock does
  AST_TDO_FALL: assert property (scanEnable && $changed(tdo) |-> !$past(tck, 2))
    else $error("serial output moved outside a falling test clock");
  AST_OE_FALL: assert property ($fell(tdoOe_n) |-> !$past(tck, 2))
    else $error("output enable asserted outside a falling test clock");
  AST_SEL_ONEHOT: assert property ($onehot0({userInstrOneSelect, userInstrTwoSelect,
    configLoadSelect, readbackSelect}))
    else $error("more than one instruction select active");
  AST_CFG_STROBE: assert property (configShiftStrobe |->
    configLoadSelect ##0 sOnePulse(configShiftStrobe))
    else $error("configuration strobe not a single pulse under load");
  AST_RB_STROBE: assert property (readbackShiftStrobe |->
    readbackSelect ##0 sOnePulse(readbackShiftStrobe))
    else $error("readback strobe not a single pulse under readback");
endmodule // user_scan_macro_checker

bind user_scan_macro_top user_scan_macro_checker propsChk (
  .clk(clk), .rst_n(rst_n), .scanEnable(scanEnable), .tck(tck), .tdo(tdo),
  .tdoOe_n(tdoOe_n), .padOut(padOut), .padOe_n(padOe_n), .coreOut(coreOut),
  .coreOe_n(coreOe_n), .modeSelectBitOne(modeSelectBitOne), .modeOneCoreOut(modeOneCoreOut),
  .userInstrOneSelect(userInstrOneSelect), .userInstrTwoSelect(userInstrTwoSelect),
  .userDataRegClock(userDataRegClock), .userTckRuntestGate(userTckRuntestGate),
  .configLoadSelect(configLoadSelect), .configShiftStrobe(configShiftStrobe),
  .readbackSelect(readbackSelect), .readbackShiftStrobe(readbackShiftStrobe)
);

`default_nettype wire

// ===== tb.sv
// Self-checking bench for the boundary-scan test logic.
// Assumes the controller model drives the test pins; the bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
`include "user_scan_macro_consts.vh"

module tb;
  localparam logic [20:0] PAT = 21'h1a5c3e;
  logic clk = 1'b0, rst_n = 1'b0, scanEnable = 1'b1;
  logic [3:0] padIn = 4'ha, coreOut = 4'h5, coreOe_n = 4'h3, padOut, padOe_n, ePad, eOe;
  logic modeZero = 1'b1, modeTwo = 1'b0, modeOneOut = 1'b1, modeOneOe_n = 1'b0;
  logic obsEn = 1'b1, obsVal = 1'b0, chainOne = 1'b0, chainTwo = 1'b0;
  logic cfgOut = 1'b0, rbIn = 1'b0, d;
  logic tck, tms, tdi, tdo, tdoOe_n, modeOne, modeOneOe, updCell, selOne, selTwo;
  logic drClk, idleGate, dataIn, cfgSel, cfgStb, rbSel, rbStb;
  logic [2:0] cap;
  logic [20:0] dout, exp, u;
  logic drPrev = 1'b0;
  int failures = 0, tests_run = 0, strobes = 0, gateLow = 0, drPulses = 0;
  // A released serial line floats to the board pull-up
  wire logic tdoLine = tdoOe_n ? 1'b1 : tdo;

  user_scan_macro_top uut (
    .clk(clk), .rst_n(rst_n), .scanEnable(scanEnable), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdoOe_n(tdoOe_n), .padIn(padIn), .padOut(padOut), .padOe_n(padOe_n),
    .coreOut(coreOut), .coreOe_n(coreOe_n), .modeSelectBitZero(modeZero),
    .modeSelectBitTwo(modeTwo), .modeSelectBitOne(modeOne), .modeSelectBitOneOe_n(modeOneOe),
    .modeOneCoreOut(modeOneOut), .modeOneCoreOe_n(modeOneOe_n), .obsEnableProbe(obsEn),
    .obsValueProbe(obsVal), .scanInternalUpdateCell(updCell), .userInstrOneSelect(selOne),
    .userInstrTwoSelect(selTwo), .userChainOneSerialIn(chainOne),
    .userChainTwoSerialIn(chainTwo), .userDataRegClock(drClk), .userTckRuntestGate(idleGate),
    .scanDataIn(dataIn), .configLoadSelect(cfgSel), .configShiftStrobe(cfgStb),
    .configSerialOut(cfgOut), .readbackSelect(rbSel), .readbackShiftStrobe(rbStb),
    .readbackSerialIn(rbIn));
  test_ctl_model ctl (.clk(clk), .tdo(tdoLine), .tck(tck), .tms(tms), .tdi(tdi));

  initial
  begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    strobes <= strobes + int'(cfgStb | rbStb);
    gateLow <= gateLow + int'(!idleGate);
    drPrev <= drClk;
    drPulses <= drPulses + int'(drClk & ~drPrev);
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] want);
    tests_run++;
    if (got !== want)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic irLoad(input logic [2:0] code, output logic [2:0] capt);
    logic [20:0] o;
    ctl.scan(1'b1, 3, {18'h0, code}, o);
    capt = o[2:0];
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  initial
  begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk({tdoOe_n, idleGate}, 2'h3);
    ctl.tapReset();
    irLoad(3'h7, cap);
    chk({tdoOe_n, cap}, 4'h9);
    for (int k = 6; k < 8; k++)
    begin
      irLoad(k[2:0], cap);
      drPulses = 0;
      ctl.scan(1'b0, 21, PAT, dout);
      chk(dout, {PAT[19:0], 1'b0});
      // One pulse entering capture, one in capture, one per shift
      chk(drPulses, 23);
    end
    irLoad(3'h1, cap);
    ctl.scan(1'b0, 21, PAT, dout);
    exp = '0;
    exp[1:0] = {obsVal, obsEn};
    for (int p = 0; p < 4; p++)
      exp[2+3*p +: 3] = {coreOe_n[p], coreOut[p], padIn[p]};
    exp[20:14] = {PAT[0], 1'b0, modeOneOe_n, modeOneOut, modeOneOut, modeTwo, modeZero};
    chk(dout, exp);
    u = {1'b0, PAT[20:1]};
    padIn = 4'h6;
    irLoad(3'h0, cap);
    for (int p = 0; p < 4; p++)
      {eOe[p], ePad[p]} = u[3+3*p +: 2];
    chk({modeOne, modeOneOe, updCell, padOe_n, padOut}, {u[17], u[18], u[19], eOe, ePad});
    ctl.scan(1'b0, 21, {u[19:0], 1'b0}, dout);
    exp = '0;
    exp[1:0] = {obsVal, obsEn};
    for (int p = 0; p < 4; p++)
      exp[2+3*p +: 3] = {coreOe_n[p], coreOut[p], padIn[p]};
    exp[20:14] = {1'b0, 1'b0, modeOneOe_n, modeOneOut, u[17], modeTwo, modeZero};
    chk(dout, exp);
    for (int k = 0; k < 2; k++)
    begin
      chainOne = (k == 1);
      chainTwo = (k == 0);
      irLoad(3'h2 + k[2:0], cap);
      chk({selTwo, selOne}, 2'h1 << k);
      ctl.scan(1'b0, 21, PAT, dout);
      chk(dout, 21'h000000);
    end
    for (int k = 0; k < 2; k++)
    begin
      cfgOut = (k == 1);
      rbIn = (k == 0);
      irLoad(k ? 3'h4 : 3'h5, cap);
      chk({rbSel, cfgSel}, 2'h1 << k);
      strobes = 0;
      ctl.scan(1'b0, 21, PAT, dout);
      chk({strobes, dout}, {32'd21, 21'h000000});
    end
    ctl.tapReset();
    chk({rbSel, cfgSel}, 2'h0);
    gateLow = 0;
    repeat (2) ctl.step(1'b0, ~tdi, d);
    chk(gateLow > 3, 1'b1);
    chk(dataIn, tdi);
    scanEnable = 1'b0;
    ctl.tapReset();
    irLoad(3'h2, cap);
    chk({selOne, tdoOe_n}, 2'h1);
    tally_and_finish();
  end
endmodule // tb

`default_nettype wire
